// [hw/bccr_pkg.sv]
// Shared constants and types for the bus clock and reset compliance block.
package bccr_pkg;
	localparam int          LANES         = 4;
	localparam int          AW            = 2;
	localparam int          CNT_W         = 4;
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          PD_TIME_NS    = 500;
	localparam int          PU_TIME_NS    = 500;
	localparam int          PD_CYC_I      = (PD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PU_CYC_I      = (PU_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  PD_CYC        = 4'(PD_CYC_I < 1 ? 1 : PD_CYC_I);
	localparam logic [3:0]  PU_CYC        = 4'(PU_CYC_I < 1 ? 1 : PU_CYC_I);
	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_ONE       = 4'h1;
	localparam logic [1:0]  SZ_BYTE       = 2'h0;
	localparam logic [1:0]  SZ_HALF       = 2'h1;
	localparam logic [3:0]  MASK_BYTE     = 4'h1;
	localparam logic [3:0]  MASK_HALF     = 4'h3;
	localparam logic [3:0]  MASK_WORD     = 4'hF;
	localparam logic [1:0]  LOW_BYTE      = 2'h0;
	localparam logic [1:0]  LOW_HALF      = 2'h1;
	localparam logic [1:0]  LOW_WORD      = 2'h3;
	localparam logic [1:0]  ADDR_ZERO     = 2'h0;

	typedef enum logic [4:0] {
		ST_RUN  = 5'h01,
		ST_PDN  = 5'h02,
		ST_LOW  = 5'h04,
		ST_PUP  = 5'h08,
		ST_DENY = 5'h10
	} bccr_lp_t;
endpackage

// [hw/bccr_lane_if.sv]
// Carrier between the sequencer and the byte-lane calculator.
`timescale 1ns/1ns
`default_nettype none
interface bccr_lane_if;
	logic [1:0] addr;
	logic [1:0] size;
	logic       first;
	logic [3:0] mask;
	logic [1:0] next_addr;

	modport req (output addr, output size, output first, input mask, input next_addr);
	modport calc (input addr, input size, input first, output mask, output next_addr);
endinterface
`default_nettype wire

// [hw/bccr_lane_calc.sv]
// Byte-lane mask and next beat address for incrementing bursts on a 32-bit bus.
`timescale 1ns/1ns
`default_nettype none
module bccr_lane_calc
	import bccr_pkg::*;
(
	bccr_lane_if.calc lif
);
	// Low address bits that a given size ignores; sizes above a word are clamped.
	function automatic logic [1:0] low_bits(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: low_bits = LOW_BYTE;
			SZ_HALF: low_bits = LOW_HALF;
			default: low_bits = LOW_WORD;
		endcase
	endfunction

	// Lanes that one transfer of the size occupies at lane zero.
	function automatic logic [3:0] size_mask(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: size_mask = MASK_BYTE;
			SZ_HALF: size_mask = MASK_HALF;
			default: size_mask = MASK_WORD;
		endcase
	endfunction

	logic [1:0] aligned;
	logic [3:0] full_mask;

	// The first beat drops lanes below the start address; later beats are full.
	always_comb begin
		aligned       = lif.addr & ~low_bits(lif.size);
		full_mask     = size_mask(lif.size) << aligned;
		lif.mask      = lif.first ? (full_mask & (MASK_WORD << lif.addr)) : full_mask;
		lif.next_addr = 2'(aligned + low_bits(lif.size) + 2'h1);
	end
endmodule
`default_nettype wire

// [hw/bccr_top.sv]
// Clock, reset and low-power clock control sequencer for a slave bus port.
`timescale 1ns/1ns
`default_nettype none
module bccr_top
	import bccr_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       ext_rst_n,
	input  wire logic       rvalid_in,
	input  wire logic       bvalid_in,
	input  wire logic       arvalid,
	input  wire logic       awvalid,
	input  wire logic       wvalid,
	input  wire logic       csysreq,
	input  wire logic       pd_seq_en,
	input  wire logic       busy,
	input  wire logic       burst_start,
	input  wire logic       beat_adv,
	input  wire logic [1:0] start_addr,
	input  wire logic [1:0] start_size,
	output logic            aresetn_o,
	output logic            rvalid,
	output logic            bvalid,
	output logic            master_err,
	output logic            cactive,
	output logic            csysack,
	output logic [3:0]      lane_mask
);
	logic       rst_meta_r;
	logic       aresetn_r;
	logic       rvalid_r;
	logic       bvalid_r;
	logic       master_err_r;
	logic       req_meta_r;
	logic       req_sync_r;
	logic       cactive_r;
	logic       csysack_r;
	logic [3:0] lp_cnt_r;
	logic [3:0] lane_mask_r;
	logic [1:0] beat_addr_r;
	logic [1:0] beat_size_r;
	logic       first_r;
	bccr_lp_t   lp_state_r;

	bccr_lane_if lif ();

	bccr_lane_calc u_lane (
		.lif (lif.calc)
	);

	// Release of the bus reset is retimed by two flops; assertion is immediate.
	always_ff @(posedge ref_clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			rst_meta_r <= 1'b0;
			aresetn_r  <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			aresetn_r  <= rst_meta_r;
		end
	end

	// Response valids are registered and cleared the moment the pin reset falls.
	always_ff @(posedge ref_clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			rvalid_r <= 1'b0;
			bvalid_r <= 1'b0;
		end else if (rst || !aresetn_r) begin
			rvalid_r <= 1'b0;
			bvalid_r <= 1'b0;
		end else begin
			rvalid_r <= rvalid_in;
			bvalid_r <= bvalid_in;
		end
	end

	// A master VALID seen while the bus is in reset is latched as a fault.
	// Payload signals are never checked here since they are don't-care in reset.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			master_err_r <= 1'b0;
		end else if (!aresetn_r && (arvalid || awvalid || wvalid)) begin
			master_err_r <= 1'b1;
		end
	end

	// The controller request comes from another block, so it is synchronised.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_meta_r <= 1'b1;
			req_sync_r <= 1'b1;
		end else begin
			req_meta_r <= csysreq;
			req_sync_r <= req_meta_r;
		end
	end

	// Low-power handshake. Without a sequence the block reports its own need for
	// the clock and mirrors the request; with one it leaves run only on a request and wakes on a request or busy.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lp_state_r <= ST_RUN;
			cactive_r  <= 1'b1;
			csysack_r  <= 1'b1;
			lp_cnt_r   <= CNT_ZERO;
		end else if (!pd_seq_en) begin
			lp_state_r <= ST_RUN;
			cactive_r  <= busy;
			csysack_r  <= req_sync_r;
			lp_cnt_r   <= CNT_ZERO;
		end else begin
			case (lp_state_r)
				ST_RUN: begin
					cactive_r <= 1'b1;
					if (!req_sync_r && csysack_r) begin
						if (busy) begin
							csysack_r  <= 1'b0;
							lp_state_r <= ST_DENY;
						end else begin
							lp_cnt_r   <= PD_CYC;
							lp_state_r <= ST_PDN;
						end
					end
				end
				ST_PDN: begin
					if (lp_cnt_r == CNT_ONE) begin
						cactive_r  <= 1'b0;
						csysack_r  <= 1'b0;
						lp_state_r <= ST_LOW;
					end
					lp_cnt_r <= 4'(lp_cnt_r - CNT_ONE);
				end
				ST_LOW: begin
					if (req_sync_r || busy) begin
						cactive_r  <= 1'b1;
						lp_cnt_r   <= PU_CYC;
						lp_state_r <= ST_PUP;
					end
				end
				ST_PUP: begin
					// Acknowledge waits for both the wake-up time and the raised request.
					if (lp_cnt_r != CNT_ZERO) begin
						lp_cnt_r <= 4'(lp_cnt_r - CNT_ONE);
					end else if (req_sync_r) begin
						csysack_r  <= 1'b1;
						lp_state_r <= ST_RUN;
					end
				end
				ST_DENY: begin
					if (req_sync_r) begin
						csysack_r  <= 1'b1;
						lp_state_r <= ST_RUN;
					end
				end
				default: begin
					lp_state_r <= ST_RUN;
					cactive_r  <= 1'b1;
					csysack_r  <= 1'b1;
				end
			endcase
		end
	end

	// Burst beat tracking feeds the lane calculator; the mask is then registered.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			beat_addr_r <= ADDR_ZERO;
			beat_size_r <= SZ_BYTE;
			first_r     <= 1'b0;
		end else if (burst_start) begin
			beat_addr_r <= start_addr;
			beat_size_r <= start_size;
			first_r     <= 1'b1;
		end else if (beat_adv) begin
			beat_addr_r <= lif.next_addr;
			first_r     <= 1'b0;
		end
	end

	assign lif.addr  = beat_addr_r;
	assign lif.size  = beat_size_r;
	assign lif.first = first_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lane_mask_r <= MASK_WORD;
		end else begin
			lane_mask_r <= lif.mask;
		end
	end

	// Every output is a flop, so only the pin reset (ext_rst_n, clearing aresetn_r, rvalid_r, bvalid_r) reaches an output in the same cycle.
	assign aresetn_o  = aresetn_r;
	assign rvalid     = rvalid_r;
	assign bvalid     = bvalid_r;
	assign master_err = master_err_r;
	assign cactive    = cactive_r;
	assign csysack    = csysack_r;
	assign lane_mask  = lane_mask_r;

	AST_RV_LOW: assert property (@(posedge ref_clk) !aresetn_r |=> !rvalid_r)
		else $error("rvalid high during bus reset");
	AST_BV_LOW: assert property (@(posedge ref_clk) !aresetn_r |=> !bvalid_r)
		else $error("bvalid high during bus reset");
	// The pin must have stood high at both earlier edges, so one stage alone cannot pass.
	AST_REL_SYNC: assert property (@(posedge ref_clk)
		$rose(aresetn_r) |-> $past(ext_rst_n) && $past(ext_rst_n, 2))
		else $error("reset released without two edges");
	// The pin reset clears the flop between edges, so it ends any attempt in flight.
	AST_REG_PATH: assert property (@(posedge ref_clk) disable iff (rst || !ext_rst_n)
		aresetn_r && $past(aresetn_r) && bvalid_in |=> bvalid_r)
		else $error("bvalid not registered from core");
	AST_MERR: assert property (@(posedge ref_clk) disable iff (rst)
		!aresetn_r && wvalid |=> master_err_r)
		else $error("master valid in reset not flagged");
	AST_ENTRY: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(csysack_r) && lp_state_r == ST_LOW |-> !cactive_r)
		else $error("low state acknowledged with clock demand");
	AST_DENY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		lp_state_r == ST_DENY |-> cactive_r && !csysack_r)
		else $error("denial without activity high");
	AST_NOSEQ: assert property (@(posedge ref_clk) disable iff (rst)
		!pd_seq_en ##1 !pd_seq_en |-> cactive_r == $past(busy))
		else $error("activity not tracking core need");
	AST_PD_TIME: assert property (@(posedge ref_clk) disable iff (rst)
		lp_state_r == ST_RUN ##1 lp_state_r == ST_PDN && pd_seq_en |-> ##[1:16] !csysack_r)
		else $error("power-down did not complete in time");
	AST_FIRST_LANE: assert property (@(posedge ref_clk) disable iff (rst)
		first_r |=> (lane_mask_r & ~(MASK_WORD << $past(beat_addr_r))) == 4'h0)
		else $error("first beat uses lane below start");

	COV_ACCEPT: cover property (@(posedge ref_clk) lp_state_r == ST_PDN ##[1:16] lp_state_r == ST_LOW);
	COV_DENY: cover property (@(posedge ref_clk) lp_state_r == ST_DENY ##[1:20] lp_state_r == ST_RUN);
	COV_WAKE: cover property (@(posedge ref_clk) lp_state_r == ST_PUP ##[1:20] csysack_r);
	COV_UNALIGNED: cover property (@(posedge ref_clk) burst_start && start_addr != ADDR_ZERO);
endmodule
`default_nettype wire

// [dv/bccr_ctl_model.sv]
// Behavioural system clock controller facing the low-power port.
`timescale 1ns/1ns
`default_nettype none
module bccr_ctl_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic want_low,
	input  wire logic cactive,
	input  wire logic csysack,
	output logic      csysreq
);
	logic served_r;

	// A raised activity flag while acknowledged low ends the request, as does a deny.
	always_ff @(posedge ref_clk) begin
		if (rst || !want_low) begin
			csysreq  <= 1'b1;
			served_r <= 1'b0;
		end else if (!csysreq && !csysack && cactive) begin
			csysreq  <= 1'b1;
			served_r <= 1'b1;
		end else if (!served_r) begin
			csysreq  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the clock, reset and low-power sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import bccr_pkg::*;
	logic       ref_clk, rst, ext_rst_n, rvalid_in, bvalid_in, arvalid, awvalid, wvalid;
	logic       want_low, pd_seq_en, busy, burst_start, beat_adv, csysreq;
	logic [1:0] start_addr, start_size;
	logic       aresetn_o, rvalid, bvalid, master_err, cactive, csysack, ex_r, ex_b, ex_k;
	logic [3:0] lane_mask;
	int         n_errors, checks_done, i, seed;

	bccr_top i_dut (.ref_clk(ref_clk), .rst(rst), .ext_rst_n(ext_rst_n),
		.rvalid_in(rvalid_in), .bvalid_in(bvalid_in), .arvalid(arvalid),
		.awvalid(awvalid), .wvalid(wvalid), .csysreq(csysreq), .pd_seq_en(pd_seq_en),
		.busy(busy), .burst_start(burst_start), .beat_adv(beat_adv),
		.start_addr(start_addr), .start_size(start_size), .aresetn_o(aresetn_o),
		.rvalid(rvalid), .bvalid(bvalid), .master_err(master_err), .cactive(cactive),
		.csysack(csysack), .lane_mask(lane_mask));
	bccr_ctl_model i_ctl (.ref_clk(ref_clk), .rst(rst), .want_low(want_low),
		.cactive(cactive), .csysack(csysack), .csysreq(csysreq));

	// Free-running clock at 10 MHz.
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Inputs always move the same small delay after the rising edge.
	task automatic step;
		@(posedge ref_clk);
		#10;
	endtask

	task automatic wait_ack(input logic v);
		int k;
		k = 0;
		while (csysack !== v && k < 60) begin
			step;
			k++;
		end
		chk("csysack", 4'(v), 4'(csysack));
	endtask

	task automatic report_and_stop;
		$display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Lanes of the first beat stop at the size boundary; later beats use the full size.
	function automatic logic [3:0] exp_mask(input logic [1:0] a, s, input bit second);
		int b, base;
		b = (s >= 2'h2) ? 4 : (1 << s);
		base = a & ~(b - 1);
		if (second) return 4'(((1 << b) - 1) << ((base + b) % 4));
		return 4'((((1 << b) - 1) << base) & (15 << a));
	endfunction

	// The watchdog allows many times the expected run length.
	initial begin
		#(20000 * 100);
		n_errors++;
		report_and_stop;
	end

	initial begin
		seed = 32'hf40dfef3;
		{rvalid_in, bvalid_in, arvalid, awvalid, wvalid, busy} = 6'h00;
		{want_low, burst_start, beat_adv, ext_rst_n, ex_r, ex_b, ex_k} = 7'h00;
		{start_addr, start_size, n_errors, checks_done} = '0;
		{rst, pd_seq_en} = 2'h3;
		repeat (6) @(posedge ref_clk);
		#10;
		rst = 1'b0;
		ext_rst_n = 1'b1;
		repeat (3) step;
		chk("aresetn_o", 4'h1, 4'(aresetn_o));
		// Random response and master traffic after reset has been released.
		for (i = 0; i < 200; i++) begin
			step;
			chk("rvalid", 4'(ex_r), 4'(rvalid));
			chk("bvalid", 4'(ex_b), 4'(bvalid));
			chk("master_err", 4'h0, 4'(master_err));
			{rvalid_in, bvalid_in, arvalid, awvalid} = 4'($random(seed));
			{ex_r, ex_b} = {rvalid_in, bvalid_in};
		end
		$display("test response valids done");
		// Asynchronous bus reset in mid-run with a master valid raised.
		{rvalid_in, bvalid_in, arvalid, awvalid} = 4'hC;
		step;
		ext_rst_n = 1'b0;
		wvalid = 1'b1;
		#1;
		chk("rvalid async", 4'h0, 4'({rvalid, bvalid}));
		chk("aresetn async", 4'h0, 4'(aresetn_o));
		step;
		chk("master_err set", 4'h1, 4'(master_err));
		chk("valids held", 4'h0, 4'({rvalid, bvalid}));
		{wvalid, rvalid_in, bvalid_in, ext_rst_n} = 4'h1;
		step;
		chk("aresetn first edge", 4'h0, 4'(aresetn_o));
		step;
		chk("aresetn second edge", 4'h1, 4'(aresetn_o));
		step;
		chk("master_err sticky", 4'h1, 4'(master_err));
		rst = 1'b1;
		step;
		rst = 1'b0;
		step;
		chk("master_err clear", 4'h0, 4'(master_err));
		$display("test bus reset done");
		// Every start address and size, first and second beat.
		for (i = 0; i < 16; i++) begin
			{start_size, start_addr} = 4'(i);
			burst_start = 1'b1;
			step;
			burst_start = 1'b0;
			repeat (2) step;
			chk("lane first", exp_mask(start_addr, start_size, 0), lane_mask);
			beat_adv = 1'b1;
			step;
			beat_adv = 1'b0;
			repeat (2) step;
			chk("lane next", exp_mask(start_addr, start_size, 1), lane_mask);
		end
		$display("test byte lanes done");
		// Accept with peripheral exit, accept with controller exit, then deny.
		want_low = 1'b1;
		wait_ack(1'b0);
		chk("cactive accept", 4'h0, 4'(cactive));
		busy = 1'b1;
		wait_ack(1'b1);
		chk("cactive exit", 4'h1, 4'(cactive));
		{want_low, busy} = 2'h0;
		repeat (4) step;
		want_low = 1'b1;
		wait_ack(1'b0);
		chk("cactive accept", 4'h0, 4'(cactive));
		want_low = 1'b0;
		wait_ack(1'b1);
		chk("cactive exit", 4'h1, 4'(cactive));
		{want_low, busy} = 2'h3;
		wait_ack(1'b0);
		chk("cactive deny", 4'h1, 4'(cactive));
		wait_ack(1'b1);
		{want_low, busy} = 2'h0;
		$display("test low power done");
		// Without a power-down sequence the activity flag follows the core on its own.
		pd_seq_en = 1'b0;
		repeat (3) step;
		for (i = 0; i < 50; i++) begin
			step;
			chk("cactive free", 4'(ex_k), 4'(cactive));
			busy = 1'($random(seed));
			ex_k = busy;
		end
		// Without a sequence the acknowledge simply mirrors the synchronised request.
		busy = 1'b0;
		want_low = 1'b1;
		wait_ack(1'b0);
		want_low = 1'b0;
		wait_ack(1'b1);
		$display("test free clock stop done");
		report_and_stop;
	end
endmodule
`default_nettype wire
